/* File: rtl/trace_ring_defines.svh */
`ifndef TRACE_RING_DEFINES_SVH
`define TRACE_RING_DEFINES_SVH

// ****************************************************************
// Widths
// ****************************************************************
`define WORD_W        32
`define FULL_ADDR_W   36
`define HIGH_W        4
`define PTR_W         30
`define PTR_LSB       2

// ****************************************************************
// Register indices on the register port
// ****************************************************************
`define OFS_HIGH      3'h0
`define OFS_HEAD      3'h1
`define OFS_LEN       3'h2
`define OFS_CTRL      3'h3
`define OFS_STAT      3'h4
`define OFS_GEN       3'h5
`define OFS_TAIL      3'h6

// ****************************************************************
// Field positions
// ****************************************************************
`define CODE_MSB      3
`define CODE_LSB      0
`define MODE_MSB      5
`define MODE_LSB      4
`define RES_MSB       2
`define RES_LSB       0
`define WRAP_BIT      3

// ****************************************************************
// Operation codes, full-buffer modes and result codes
// ****************************************************************
`define CODE_NONE     4'h0
`define CODE_CRC      4'h1
`define CODE_TRACE    4'h2
`define MODE_OVER     2'h0
`define MODE_DISABLE  2'h1
`define MODE_STOP     2'h2
`define MODE_FLUSH    2'h3
`define RES_DONE      3'h0
`define RES_BUSY      3'h1
`define RES_UNSUPP    3'h2
`define RES_BUS_ERR   3'h3
`define RES_FAILED    3'h4
`define RES_LOCKED    3'h5
`define RES_CANCELED  3'h6

// ****************************************************************
// Reset values and steps
// ****************************************************************
`define RST_WORD      32'h0000_0000
`define RST_PTR       30'h0000_0000
`define RST_HIGH      4'h0
`define PTR_STEP      30'h0000_0001

`endif

/* File: rtl/trace_ring_pkg.sv */
`include "trace_ring_defines.svh"

package trace_ring_pkg;

  // Writer sequencer states
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_FETCH = 3'b001,
    ST_WRITE = 3'b010,
    ST_STALL = 3'b011,
    ST_FLUSH = 3'b100
  } ring_state_e;

  // One trace word from the debug logic
  typedef struct packed {
    logic                sync;
    logic [`WORD_W-1:0]  data;
  } trace_word_s;

  // One word write on the system access bus
  typedef struct packed {
    logic [`FULL_ADDR_W-1:0] addr;
    logic [`WORD_W-1:0]      data;
  } bus_wr_s;

endpackage : trace_ring_pkg

/* File: rtl/trace_skid_fifo.sv */
`timescale 1ns/1ps

module trace_skid_fifo #(
  parameter int WIDTH = 33,
  parameter int DEPTH = 2
) (
  // Clock, reset, enable
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic             ce,
  // Control
  input  wire logic             clear,
  input  wire logic             open,
  // Filling side
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  // Draining side
  output logic                  out_valid,
  output logic [WIDTH-1:0]      out_data,
  input  wire logic             out_ready
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [AW:0]      count_r;
  logic [AW:0]      count_nxt;
  logic             ready_r;
  logic             push;
  logic             pop;

  // Pointer advance with wrap at the last entry
  function automatic logic [AW-1:0] next_ptr(input logic [AW-1:0] p);
    next_ptr = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction : next_ptr

  assign push      = in_valid & ready_r & ~clear;
  assign pop       = out_valid & out_ready;
  assign out_valid = (count_r != '0);
  assign out_data  = mem_r[rd_ptr_r];
  assign in_ready  = ready_r;

  // Occupancy; ready is registered so the source sees a clean flop
  always_comb begin
    count_nxt = count_r + (AW+1)'(push) - (AW+1)'(pop);
    if (clear) begin
      count_nxt = '0;
    end
  end

  // Pointers, count and ready
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
      ready_r  <= 1'b0;
    end else if (ce) begin
      count_r <= count_nxt;
      ready_r <= open && (count_nxt < (AW+1)'(DEPTH));
      if (clear) begin
        wr_ptr_r <= '0;
        rd_ptr_r <= '0;
      end else begin
        if (push) begin
          wr_ptr_r <= next_ptr(wr_ptr_r);
        end
        if (pop) begin
          rd_ptr_r <= next_ptr(rd_ptr_r);
        end
      end
    end
  end

  // Storage needs no reset; count guards every read
  always_ff @(posedge clk) begin
    if (ce && push) begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end

endmodule : trace_skid_fifo

/* File: rtl/trace_ring_buffer_writer.sv */
`timescale 1ns/1ps
`include "trace_ring_defines.svh"

// Summary of operation
// - Trace words are taken only after the trace code is written to control.
// - High, head and length values set at start define a circular buffer.
// - Head pointer is the write pointer; tail pointer belongs to debugger.
// - Bus address is high part on bits 35:32 joined with a pointer.
// - Each write advances head and lowers remaining length.
// - At zero length, head and length reload and writing restarts at start.
// - Buffer is full when head becomes equal to tail.
// - Full mode: 0 overwrite, 1 disable, 2 break-stall, 3 break-flush.
// - Overwrite mode on full: keep writing, set wrap, ask for sync.
// - Wrap flag stays set until software writes zero to it.
// - Disable mode on full: operation ends and block goes idle.
// - Break-stall on full: request debug, stall CPU until tail written.
// - Break-flush on full: request debug, discard words that do not fit.
// - Writing tail with its own value frees the whole buffer.
// - After flush restart, first stored message is a sync message.
// - Operation code: 0 none or cancel, 1 CRC, 2 trace.
// - Result shows busy while trace runs.
// - Result shows done after reset and after full buffer in disable mode only.
// - Writing another code during trace cancels it; result shows canceled.
// - Bus error ends trace; result bus error; failing address kept.
// - Without the trace feature the result shows not implemented.
// - Result codes: 0 done to 6 canceled, others reserved.
// - Head, length and tail keep bits 1:0 at zero.
module trace_ring_buffer_writer #(
  parameter bit TRACE_PRESENT = 1'b1,
  parameter int BUF_DEPTH     = 2
) (
  // Clock, reset, enable
  input  wire logic                        clk,
  input  wire logic                        sys_rst,
  input  wire logic                        ce,
  // Register port
  input  wire logic                        reg_sel,
  input  wire logic                        reg_wr,
  input  wire logic [2:0]                  reg_addr,
  input  wire logic [`WORD_W-1:0]          reg_wdata,
  output logic      [`WORD_W-1:0]          reg_rdata,
  // Trace words from the debug logic
  input  wire logic                        trc_valid,
  input  wire trace_ring_pkg::trace_word_s trc_word,
  output logic                             trc_ready,
  // System access bus writes
  output logic                             bus_req,
  output trace_ring_pkg::bus_wr_s          bus_cmd,
  input  wire logic                        bus_ack,
  input  wire logic                        bus_err,
  // Debug logic control
  output logic                             sync_req,
  output logic                             debug_req,
  output logic                             cpu_stall,
  output logic                             trace_redirect
);
  import trace_ring_pkg::*;

  // ****************************************************************
  // Storage
  // ****************************************************************
  logic [`HIGH_W-1:0] high_r;
  logic [`PTR_W-1:0]  head_r, len_r, tail_r, base_head_r, base_len_r;
  logic [`CODE_MSB:0] code_r;
  logic [1:0]         mode_r;
  logic [`RES_MSB:0]  result_r;
  logic               wrap_r, sync_need_r;
  logic [`WORD_W-1:0] gen_r, rdata_r;
  ring_state_e        state_r, state_nxt;
  logic               bus_req_r, sync_req_r, debug_req_r, cpu_stall_r;
  logic               redirect_r;
  bus_wr_s            bus_cmd_r;

  logic               wr_ctrl, wr_stat, wr_tail, wr_idle;
  logic [`CODE_MSB:0] new_code;
  logic               start, cancel, unsupp, take, drop, pop;
  logic               acked, failed, at_end, full;
  logic [`PTR_W-1:0]  head_nxt, len_nxt;
  logic               fifo_valid, fifo_open, fifo_clear;
  trace_word_s        fifo_word;

  // Register-port write decode
  function automatic logic hit(input logic [2:0] ofs);
    hit = reg_sel && reg_wr && (reg_addr == ofs);
  endfunction : hit

  // Full bus address from the high part and a word pointer
  function automatic logic [`FULL_ADDR_W-1:0] full_addr(
    input logic [`HIGH_W-1:0] hi, input logic [`PTR_W-1:0] p);
    full_addr = {hi, p, 2'b00};
  endfunction : full_addr

  // ****************************************************************
  // Decode
  // ****************************************************************
  // The helper reads the strobes itself, so a process keeps them in view
  always_comb begin
    wr_ctrl = hit(`OFS_CTRL);
    wr_stat = hit(`OFS_STAT);
    wr_tail = hit(`OFS_TAIL);
  end
  assign wr_idle  = (state_r == ST_IDLE);
  assign new_code = reg_wdata[`CODE_MSB:`CODE_LSB];
  assign start    = wr_ctrl && wr_idle && TRACE_PRESENT &&
                    (new_code == `CODE_TRACE);
  assign cancel   = wr_ctrl && !wr_idle &&
                    (new_code != `CODE_TRACE);
  assign unsupp   = wr_ctrl && wr_idle && ((new_code == `CODE_CRC) ||
                    ((new_code == `CODE_TRACE) && !TRACE_PRESENT));

  // Word hand-off from the buffer; stale words dropped until sync
  assign pop  = (state_r == ST_FETCH) && fifo_valid && !cancel;
  assign drop = sync_need_r && !fifo_word.sync;
  assign take = pop && !drop;

  // Head advance, wrap and full detection on a completed write
  assign acked    = (state_r == ST_WRITE) && bus_ack && !cancel;
  assign failed   = (state_r == ST_WRITE) && bus_err && !cancel;
  assign len_nxt  = len_r - `PTR_STEP;
  assign at_end   = (len_nxt == `RST_PTR);
  assign head_nxt = at_end ? base_head_r : head_r + `PTR_STEP;
  assign full     = acked && (head_nxt == tail_r);

  // Source is open only where words can move on
  assign fifo_open  = (state_nxt != ST_IDLE) && (state_nxt != ST_STALL);
  assign fifo_clear = (state_r == ST_IDLE) || (state_r == ST_FLUSH);

  trace_skid_fifo #(
    .WIDTH ($bits(trace_word_s)),
    .DEPTH (BUF_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .ce        (ce),
    .clear     (fifo_clear),
    .open      (fifo_open),
    .in_valid  (trc_valid),
    .in_data   (trc_word),
    .in_ready  (trc_ready),
    .out_valid (fifo_valid),
    .out_data  (fifo_word),
    .out_ready (pop)
  );

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (start) state_nxt = ST_FETCH;
      end
      ST_FETCH: begin
        if (take) state_nxt = ST_WRITE;
      end
      ST_WRITE: begin
        if (failed) begin
          state_nxt = ST_IDLE;
        end else if (full) begin
          case (mode_r)
            `MODE_OVER:    state_nxt = ST_FETCH;
            `MODE_DISABLE: state_nxt = ST_IDLE;
            `MODE_STOP:    state_nxt = ST_STALL;
            default:       state_nxt = ST_FLUSH;
          endcase
        end else if (acked) begin
          state_nxt = ST_FETCH;
        end
      end
      ST_STALL, ST_FLUSH: begin
        if (wr_tail) state_nxt = ST_FETCH;
      end
      default: state_nxt = ST_IDLE;
    endcase
    if (cancel) state_nxt = ST_IDLE;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r    <= ST_IDLE;
      redirect_r <= 1'b0;
    end else if (ce) begin
      state_r    <= state_nxt;
      redirect_r <= (state_nxt != ST_IDLE);
    end
  end

  // ****************************************************************
  // Address registers; pointers hold word index so bits 1:0 read 0
  // ****************************************************************
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      high_r <= `RST_HIGH;
      head_r <= `RST_PTR;
      len_r  <= `RST_PTR;
      tail_r <= `RST_PTR;
      gen_r  <= `RST_WORD;
    end else if (ce) begin
      if (acked) begin
        head_r <= head_nxt;
        len_r  <= at_end ? base_len_r : len_nxt;
      end else if (wr_idle) begin
        if (hit(`OFS_HIGH)) high_r <= reg_wdata[`HIGH_W-1:0];
        if (hit(`OFS_HEAD)) head_r <= reg_wdata[`WORD_W-1:`PTR_LSB];
        if (hit(`OFS_LEN))  len_r  <= reg_wdata[`WORD_W-1:`PTR_LSB];
      end
      if (wr_tail) tail_r <= reg_wdata[`WORD_W-1:`PTR_LSB];
      if (hit(`OFS_GEN)) gen_r <= reg_wdata;
    end
  end

  // Private copies taken at start, reused at every wrap
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      base_head_r <= `RST_PTR;
      base_len_r  <= `RST_PTR;
    end else if (ce && start) begin
      base_head_r <= head_r;
      base_len_r  <= len_r;
    end
  end

  // ****************************************************************
  // Control and status
  // ****************************************************************
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      code_r <= `CODE_NONE;
      mode_r <= `MODE_OVER;
    end else if (ce) begin
      if (wr_ctrl) begin
        code_r <= new_code;
        mode_r <= reg_wdata[`MODE_MSB:`MODE_LSB];
      end else if (state_nxt == ST_IDLE && !wr_idle) begin
        code_r <= `CODE_NONE;
      end
    end
  end

  // Result code of the current or last operation
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      result_r <= `RES_DONE;
    end else if (ce) begin
      if (start)       result_r <= `RES_BUSY;
      else if (unsupp) result_r <= `RES_UNSUPP;
      else if (cancel) result_r <= `RES_CANCELED;
      else if (failed) result_r <= `RES_BUS_ERR;
      else if (full && mode_r == `MODE_DISABLE)
        result_r <= `RES_DONE;
    end
  end

  // Wrap flag: a set in the clearing cycle wins
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wrap_r <= 1'b0;
    end else if (ce) begin
      if (full && mode_r == `MODE_OVER) begin
        wrap_r <= 1'b1;
      end else if (wr_stat && !reg_wdata[`WRAP_BIT]) begin
        wrap_r <= 1'b0;
      end
    end
  end

  // Stored words after a flush must begin at a sync message
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync_need_r <= 1'b0;
    end else if (ce) begin
      if (start) sync_need_r <= 1'b0;
      else if (full && mode_r == `MODE_FLUSH) sync_need_r <= 1'b1;
      else if (take) sync_need_r <= 1'b0;
    end
  end

  // ****************************************************************
  // Bus master; cancel abandons an open write, bus must tolerate it
  // ****************************************************************
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      bus_req_r <= 1'b0;
      bus_cmd_r <= '0;
    end else if (ce) begin
      if (take) begin
        bus_req_r      <= 1'b1;
        bus_cmd_r.addr <= full_addr(high_r, head_r);
        bus_cmd_r.data <= fifo_word.data;
      end else if (acked || failed || cancel) begin
        bus_req_r <= 1'b0;
      end
    end
  end

  // Requests to the debug logic
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync_req_r  <= 1'b0;
      debug_req_r <= 1'b0;
      cpu_stall_r <= 1'b0;
    end else if (ce) begin
      sync_req_r <= (full && mode_r == `MODE_OVER) ||
                    (state_r == ST_FLUSH && wr_tail);
      if (full && mode_r[1]) begin
        debug_req_r <= 1'b1;
        cpu_stall_r <= (mode_r == `MODE_STOP);
      end else if (wr_tail || cancel) begin
        debug_req_r <= 1'b0;
        cpu_stall_r <= 1'b0;
      end
    end
  end

  // Read data, one cycle after the read access
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_r <= `RST_WORD;
    end else if (ce && reg_sel && !reg_wr) begin
      rdata_r <= `RST_WORD;
      case (reg_addr)
        `OFS_HIGH: rdata_r[`HIGH_W-1:0] <= high_r;
        `OFS_HEAD: rdata_r <= {head_r, 2'b00};
        `OFS_LEN:  rdata_r <= {len_r, 2'b00};
        `OFS_CTRL: begin
          rdata_r[`CODE_MSB:`CODE_LSB] <= code_r;
          rdata_r[`MODE_MSB:`MODE_LSB] <= mode_r;
        end
        `OFS_STAT: begin
          rdata_r[`RES_MSB:`RES_LSB] <= result_r;
          rdata_r[`WRAP_BIT]         <= wrap_r;
        end
        `OFS_GEN:  rdata_r <= gen_r;
        `OFS_TAIL: rdata_r <= {tail_r, 2'b00};
        default:   rdata_r <= `RST_WORD;
      endcase
    end
  end

  assign reg_rdata      = rdata_r;
  assign bus_req        = bus_req_r;
  assign bus_cmd        = bus_cmd_r;
  assign sync_req       = sync_req_r;
  assign debug_req      = debug_req_r;
  assign cpu_stall      = cpu_stall_r;
  assign trace_redirect = redirect_r;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  result_busy_a: assert property (
    state_r != ST_IDLE |-> result_r == `RES_BUSY)
    else $error("result not busy while running");
  bus_address_a: assert property (
    ce && take |=> bus_req && bus_cmd.addr ==
      {$past(high_r), $past(head_r), 2'b00})
    else $error("bus address not built from high and head");
  head_step_a: assert property (
    ce && acked && !at_end |=> head_r == $past(head_r) + `PTR_STEP
      && len_r == $past(len_r) - `PTR_STEP)
    else $error("head or length did not step");
  wrap_restore_a: assert property (
    ce && acked && at_end |=> head_r == base_head_r
      && len_r == base_len_r)
    else $error("pointers not restored at buffer end");
  wrap_sticky_a: assert property (
    ce && wrap_r && !(wr_stat && !reg_wdata[`WRAP_BIT]) |=> wrap_r)
    else $error("wrap flag cleared on its own");
  stall_hold_a: assert property (
    ce && state_r == ST_STALL && !wr_tail && !cancel
      |=> cpu_stall && state_r == ST_STALL)
    else $error("stall released without tail write");
  stall_closed_a: assert property (
    ce && state_r == ST_STALL ##1 state_r == ST_STALL |-> !trc_ready)
    else $error("trace accepted during stall");
  cancel_end_a: assert property (
    ce && cancel |=> state_r == ST_IDLE
      && result_r == `RES_CANCELED && !bus_req)
    else $error("cancel did not end the operation");
  done_cause_a: assert property (
    ce && result_r != `RES_DONE ##1 result_r == `RES_DONE
      |-> $past(full) && $past(mode_r) == `MODE_DISABLE)
    else $error("done without disable on full");
  flush_sync_a: assert property (
    ce && pop && drop |=> !bus_req && state_r == ST_FETCH)
    else $error("non-sync word stored after flush");

  wrap_seen_c: cover property (acked && at_end);
  over_full_c: cover property (full && mode_r == `MODE_OVER);
  stall_exit_c: cover property (state_r == ST_STALL && wr_tail);
  flush_exit_c: cover property (state_r == ST_FLUSH ##[1:50] take);

endmodule : trace_ring_buffer_writer

/* File: verification/trace_bus_model.sv */
`timescale 1ns/1ps

// Far side: system bus memory that answers each write with one pulse
module trace_bus_model (
  // Clock and bus
  input  wire logic                    clk,
  input  wire logic                    sys_rst,
  input  wire logic                    bus_req,
  input  wire trace_ring_pkg::bus_wr_s bus_cmd,
  output logic                         bus_ack,
  output logic                         bus_err,
  // Bench control and view
  input  wire logic                    fail_en,
  output logic [35:0]                  last_addr,
  output int                           n_wr
);
  import trace_ring_pkg::*;
  logic open_r;

  assign open_r = bus_req & ~bus_ack & ~bus_err;

  // Answer drops after one cycle so one write is never answered twice
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      bus_ack   <= 1'b0;
      bus_err   <= 1'b0;
      n_wr      <= 0;
      last_addr <= '0;
    end else begin
      bus_ack <= open_r & ~fail_en;
      bus_err <= open_r & fail_en;
      if (open_r) begin
        n_wr      <= n_wr + 1;
        last_addr <= bus_cmd.addr;
      end
    end
  end
endmodule : trace_bus_model

/* File: verification/trace_ring_buffer_writer_tb.sv */
`timescale 1ns/1ps

module trace_ring_buffer_writer_tb;
  import trace_ring_pkg::*;
  logic clk = 0, sys_rst = 1, sel = 0, wr = 0, tv = 0, fe = 0, tsync = 1;
  logic [2:0] a = '0;
  logic [31:0] wd = '0, rd;
  trace_word_s tw = '0;
  logic trdy, breq, back, berr, sreq, dreq, stl, redir;
  bus_wr_s bcmd;
  logic [35:0] la;
  int nw, fails = 0, n_compared = 0, n_sync = 0;

  always #5 clk = ~clk;

  // Sync requests last one cycle, so they are counted as they pass
  always @(posedge clk) begin
    if (sreq === 1'b1) n_sync <= n_sync + 1;
  end

  trace_ring_buffer_writer u_trace_ring_buffer_writer (.clk(clk),
    .sys_rst(sys_rst), .ce(1'b1), .reg_sel(sel), .reg_wr(wr),
    .reg_addr(a), .reg_wdata(wd), .reg_rdata(rd), .trc_valid(tv),
    .trc_word(tw), .trc_ready(trdy), .bus_req(breq), .bus_cmd(bcmd),
    .bus_ack(back), .bus_err(berr), .sync_req(sreq), .debug_req(dreq),
    .cpu_stall(stl), .trace_redirect(redir));

  trace_bus_model u_trace_bus_model (.clk(clk), .sys_rst(sys_rst),
    .bus_req(breq), .bus_cmd(bcmd), .bus_ack(back), .bus_err(berr),
    .fail_en(fe), .last_addr(la), .n_wr(nw));

  // ****************************************************************
  // Access tasks
  // ****************************************************************
  task chk(input logic [35:0] s, input logic [35:0] e);
    n_compared++;
    if (s !== e) begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk

  task wreg(input logic [2:0] i, input logic [31:0] d);
    @(posedge clk);
    sel <= 1;
    wr <= 1;
    a <= i;
    wd <= d;
    @(posedge clk);
    sel <= 0;
    wr <= 0;
  endtask : wreg

  // Read data lands at the taking edge and is checked just after it
  task rreg(input logic [2:0] i, input logic [31:0] e);
    @(posedge clk);
    sel <= 1;
    a <= i;
    @(posedge clk);
    sel <= 0;
    #1 chk({4'h0, rd}, {4'h0, e});
  endtask : rreg

  // Word held until taken, then the bus write it causes is awaited
  task push(input logic [31:0] d, input logic [35:0] e);
    int k;
    int n0;
    n0 = nw;
    @(posedge clk);
    tv <= 1;
    tw <= '{sync: tsync, data: d};
    @(posedge clk);
    for (k = 0; k < 50 && trdy !== 1'b1; k++) @(posedge clk);
    tv <= 0;
    for (k = 0; k < 50 && nw == n0; k++) @(posedge clk);
    repeat (3) @(posedge clk);
    chk(la, e);
  endtask : push

  task test_done;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : test_done

  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    #100000;
    fails++;
    test_done;
  end

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    repeat (2) @(posedge clk);
    sys_rst <= 0;
    rreg(3'h3, 0);
    rreg(3'h4, 0);
    rreg(3'h7, 0);
    $display("test reset done");
    wreg(3'h0, 32'hA);
    wreg(3'h1, 32'h100);
    wreg(3'h2, 32'h8);
    wreg(3'h6, 32'h100);
    chk({35'h0, trdy}, 0);
    wreg(3'h3, 32'h2);
    rreg(3'h4, 32'h1);
    push(32'h11, 36'hA_0000_0100);
    chk({4'h0, bcmd.data}, 36'h11);
    rreg(3'h1, 32'h104);
    rreg(3'h2, 32'h4);
    push(32'h22, 36'hA_0000_0104);
    rreg(3'h1, 32'h100);
    rreg(3'h4, 32'h9);
    chk(n_sync, 1);
    push(32'h33, 36'hA_0000_0100);
    rreg(3'h4, 32'h9);
    wreg(3'h4, 0);
    rreg(3'h4, 32'h1);
    wreg(3'h3, 0);
    rreg(3'h4, 32'h6);
    $display("test overwrite done");
    wreg(3'h1, 32'h203);
    rreg(3'h1, 32'h200);
    wreg(3'h6, 32'h200);
    wreg(3'h2, 32'h8);
    wreg(3'h3, 32'h12);
    push(32'h44, 36'hA_0000_0200);
    push(32'h55, 36'hA_0000_0204);
    rreg(3'h4, 0);
    chk({35'h0, redir}, 0);
    $display("test disable done");
    wreg(3'h1, 32'h400);
    wreg(3'h6, 32'h400);
    wreg(3'h3, 32'h22);
    push(32'h66, 36'hA_0000_0400);
    push(32'h77, 36'hA_0000_0404);
    chk({34'h0, dreq, stl}, 3);
    wreg(3'h6, 32'h400);
    #1 chk({34'h0, dreq, stl}, 0);
    wreg(3'h3, 0);
    wreg(3'h3, 32'h1);
    rreg(3'h4, 32'h2);
    $display("test stall done");
    wreg(3'h1, 32'h500);
    wreg(3'h6, 32'h500);
    wreg(3'h3, 32'h32);
    push(32'h99, 36'hA_0000_0500);
    push(32'hAA, 36'hA_0000_0504);
    chk({34'h0, dreq, stl}, 2);
    push(32'hBB, 36'hA_0000_0504);
    chk(nw, 9);
    wreg(3'h6, 32'h500);
    tsync <= 0;
    push(32'hCC, 36'hA_0000_0504);
    tsync <= 1;
    push(32'hDD, 36'hA_0000_0500);
    chk(n_sync, 2);
    wreg(3'h3, 0);
    $display("test flush done");
    @(posedge clk);
    fe <= 1;
    wreg(3'h1, 32'h300);
    wreg(3'h3, 32'h2);
    push(32'h88, 36'hA_0000_0300);
    rreg(3'h4, 32'h3);
    rreg(3'h1, 32'h300);
    $display("test bus error done");
    test_done;
  end
endmodule : trace_ring_buffer_writer_tb
